// ==== hdl/beh_top.sv ====
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module beh_top (
  input wire logic pclk,
  input wire logic presetn,
  // register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [beh_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [2:0] pprot,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // processor side, same clock
  input wire logic cpu_as_n,
  input wire logic cpu_write,
  input wire logic cpu_super,
  input wire logic cpu_iack,
  input wire logic [2:0] cpu_ack_level,
  input wire beh_pkg::beh_target_e cpu_target,
  input wire logic cpu_ram_wp,
  input wire logic cpu_reset_instr,
  input wire logic timer_irq,
  input wire logic serial_comm_adapter_irq,
  output logic processor_bus_error_n,
  output logic [2:0] cpu_ipl_n,
  output logic cpu_dtack_n,
  output logic cpu_autovec_n,
  output logic [7:0] cpu_vector,
  output logic cpu_spurious,
  // external bus pins
  input wire logic vme_dtack_n,
  input wire logic vme_berr_n,
  input wire logic vme_grant_n,
  input wire logic [7:1] vme_irq_n,
  input wire logic [7:0] vme_data,
  input wire logic acfail_n,
  input wire logic sysfail_n,
  input wire logic abort_n,
  output logic vme_bus_req_n,
  output logic vme_as_n,
  output logic vme_ds0_n,
  output logic vme_iack_n,
  output logic [2:0] vme_ack_level,
  // expansion channel pins
  input wire logic expansion_ack_n,
  input wire logic [4:1] expansion_irq_n,
  output logic expansion_strobe_n,
  output logic expansion_reset_n
);
  import beh_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  beh_sync_if sy ();

  assign sy.raw = {vme_data, vme_irq_n, expansion_irq_n, abort_n, sysfail_n, acfail_n,
                   expansion_ack_n, vme_grant_n, vme_berr_n, vme_dtack_n};

  beh_sync_bank u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .sy(sy)
  );

  wire dtack = ~sy.clean[SY_DTACK];
  wire berr = ~sy.clean[SY_BERR];
  wire grant = ~sy.clean[SY_GRANT];
  wire expansion_ack = ~sy.clean[SY_EXP_ACK];
  wire acfail = ~sy.clean[SY_ACFAIL];
  wire sysfail = ~sy.clean[SY_SYSFAIL];
  wire abort = ~sy.clean[SY_ABORT];
  wire [3:0] xirq = ~sy.clean[SY_XIRQ +: 4];
  wire [6:0] virq = ~sy.clean[SY_VIRQ +: 7];
  wire [7:0] vdata = sy.clean[SY_DATA +: 8];

  //////////////////////////////////////////////////////////////////////////////
  // register bus slave, one wait state

  logic [7:0] ctrl_q;
  logic [15:0] vtmo_q;
  logic [15:0] xtmo_q;
  logic [3:0] cause_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  wire acc = psel & penable & ~pready_q;
  wire fire_wr = psel & penable & pready_q & pwrite & ~pslverr_q;
  wire sel_ctrl = (paddr == REG_CTRL_OFS);
  wire sel_stat = (paddr == REG_STAT_OFS);
  wire sel_vtmo = (paddr == REG_VTMO_OFS);
  wire sel_xtmo = (paddr == REG_XTMO_OFS);
  wire mapped = sel_ctrl | sel_stat | sel_vtmo | sel_xtmo;
  // status is read-only; control writes need a privileged access
  wire bad_wr = pwrite & (sel_stat | (sel_ctrl & ~pprot[PPROT_PRIV_BIT]));
  wire err_d = ~mapped | bad_wr;
  wire protect_mode_bit = ctrl_q[CTRL_PROTECT_MODE_BIT];
  wire watchdog_enable_bit = ctrl_q[CTRL_WATCHDOG_ENABLE_BIT];

  logic [7:0] stat_w;
  assign stat_w = {cause_q, 1'b0, abort, sysfail, acfail};

  wire [31:0] rd_d = sel_ctrl ? {24'h00_0000, ctrl_q} :
                     sel_stat ? {24'h00_0000, stat_w} :
                     sel_vtmo ? {16'h0000, vtmo_q} :
                     sel_xtmo ? {16'h0000, xtmo_q} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= acc;
      pslverr_q <= acc & err_d;
      prdata_q <= (acc & ~pwrite & mapped) ? rd_d : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
      vtmo_q <= VTMO_RST;
      xtmo_q <= XTMO_RST;
    end else if (fire_wr) begin
      if (sel_ctrl) begin
        ctrl_q <= pwdata[7:0];
      end
      if (sel_vtmo) begin
        vtmo_q <= pwdata[15:0];
      end
      if (sel_xtmo) begin
        xtmo_q <= pwdata[15:0];
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  //////////////////////////////////////////////////////////////////////////////
  // interrupt priority

  logic [7:1] g1;
  logic [7:1] g0;
  logic [2:0] top_lvl;
  logic [2:0] ipl_q;

  // three fail sources share level 7
  assign g1[7] = acfail | sysfail | abort;
  assign g1[6] = timer_irq;
  assign g1[5] = serial_comm_adapter_irq;
  assign g1[4:1] = xirq;
  // external line n asks level n
  assign g0 = virq;

  always_comb begin
    top_lvl = 3'd0;
    for (int i = 1; i < 8; i++) begin
      if (g1[i] | g0[i]) begin
        top_lvl = 3'(i);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ipl_q <= 3'd0;
    end else begin
      ipl_q <= top_lvl;
    end
  end

  assign cpu_ipl_n = ~ipl_q;

  //////////////////////////////////////////////////////////////////////////////
  // cycle monitor

  logic cause_hit;
  beh_cause_e prot_cause;

  always_comb begin
    prot_cause = CAUSE_NONE;
    case (cpu_target)
      TGT_ROM: if (cpu_write) prot_cause = CAUSE_ROM_WR;
      TGT_STATUS: if (cpu_write) prot_cause = CAUSE_STAT_WR;
      TGT_CONTROL: if (cpu_write && !cpu_super) prot_cause = CAUSE_CTRL_USER;
      TGT_TIMER: if (!cpu_super && protect_mode_bit && watchdog_enable_bit) begin
        prot_cause = CAUSE_TIMER_USER;
      end
      TGT_RAM: if (cpu_write && !cpu_super && cpu_ram_wp && protect_mode_bit) begin
        prot_cause = CAUSE_RAM_WP;
      end
      default: prot_cause = CAUSE_NONE;
    endcase
  end
  assign cause_hit = (prot_cause != CAUSE_NONE);

  beh_state_e state_q;
  logic [15:0] cnt_q;
  logic iack_mode_q;
  logic berr_q;
  logic dtack_q;
  logic avec_q;
  logic [7:0] vec_q;
  logic spur_q;
  logic req_q;
  logic vas_q;
  logic vds_q;
  logic viack_q;
  logic [2:0] vlvl_q;
  logic xstb_q;
  logic xrst_q;

  wire [2:0] lv = cpu_ack_level;
  wire lv_g1 = (lv != 3'd0) & g1[lv];
  wire lv_g0 = (lv != 3'd0) & g0[lv];
  wire vme_tmo = (cnt_q >= vtmo_q);
  wire exp_tmo = (cnt_q >= xtmo_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      cnt_q <= 16'h0000;
      iack_mode_q <= 1'b0;
      berr_q <= 1'b0;
      dtack_q <= 1'b0;
      avec_q <= 1'b0;
      vec_q <= 8'h00;
      spur_q <= 1'b0;
      req_q <= 1'b0;
      vas_q <= 1'b0;
      vds_q <= 1'b0;
      viack_q <= 1'b0;
      vlvl_q <= 3'd0;
      xstb_q <= 1'b0;
      cause_q <= CAUSE_NONE;
    end else if (state_q != ST_IDLE && cpu_as_n) begin
      state_q <= ST_IDLE;
      berr_q <= 1'b0;
      dtack_q <= 1'b0;
      avec_q <= 1'b0;
      spur_q <= 1'b0;
      req_q <= 1'b0;
      vas_q <= 1'b0;
      vds_q <= 1'b0;
      viack_q <= 1'b0;
      xstb_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          cnt_q <= 16'h0000;
          iack_mode_q <= cpu_iack;
          if (!cpu_as_n) begin
            if (cpu_iack) begin
              if (lv_g1) begin
                avec_q <= 1'b1;
                vec_q <= AUTOVEC_BASE + {3'b000, lv, 2'b00};
                state_q <= ST_DONE;
              end else if (lv_g0) begin
                req_q <= 1'b1;
                vlvl_q <= lv;
                state_q <= ST_VME_REQ;
              end else begin
                berr_q <= 1'b1;
                spur_q <= 1'b1;
                cause_q <= CAUSE_SPURIOUS;
                state_q <= ST_ERR;
              end
            end else if (cause_hit) begin
              berr_q <= 1'b1;
              cause_q <= prot_cause;
              state_q <= ST_ERR;
            end else if (cpu_target == TGT_EXP) begin
              xstb_q <= 1'b1;
              state_q <= ST_EXP;
            end else if (cpu_target == TGT_VME) begin
              req_q <= 1'b1;
              state_q <= ST_VME_REQ;
            end else begin
              state_q <= ST_DONE;
            end
          end
        end
        ST_EXP: begin
          cnt_q <= cnt_q + 16'h0001;
          if (expansion_ack) begin
            dtack_q <= 1'b1;
            xstb_q <= 1'b0;
            state_q <= ST_DONE;
          end else if (exp_tmo) begin
            berr_q <= 1'b1;
            xstb_q <= 1'b0;
            cause_q <= CAUSE_EXP_TMO;
            state_q <= ST_ERR;
          end
        end
        ST_VME_REQ: begin
          cnt_q <= cnt_q + 16'h0001;
          if (vme_tmo) begin
            berr_q <= 1'b1;
            spur_q <= iack_mode_q;
            req_q <= 1'b0;
            cause_q <= CAUSE_VME_TMO;
            state_q <= ST_ERR;
          end else if (grant) begin
            vas_q <= 1'b1;
            vds_q <= 1'b1;
            viack_q <= iack_mode_q;
            state_q <= ST_VME_XFER;
          end
        end
        ST_VME_XFER: begin
          cnt_q <= cnt_q + 16'h0001;
          if (berr) begin
            berr_q <= 1'b1;
            spur_q <= iack_mode_q;
            cause_q <= CAUSE_VME_BERR;
            state_q <= ST_ERR;
          end else if (dtack) begin
            if (iack_mode_q) begin
              vec_q <= vdata;
            end
            dtack_q <= 1'b1;
            state_q <= ST_DONE;
          end else if (vme_tmo) begin
            berr_q <= 1'b1;
            spur_q <= iack_mode_q;
            cause_q <= CAUSE_VME_TMO;
            state_q <= ST_ERR;
          end
          if (berr || dtack || vme_tmo) begin
            req_q <= 1'b0;
            vas_q <= 1'b0;
            vds_q <= 1'b0;
            viack_q <= 1'b0;
          end
        end
        ST_ERR: state_q <= ST_ERR;
        ST_DONE: state_q <= ST_DONE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xrst_q <= 1'b0;
    end else begin
      xrst_q <= ~cpu_reset_instr;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign processor_bus_error_n = ~berr_q;
  assign cpu_dtack_n = ~dtack_q;
  assign cpu_autovec_n = ~avec_q;
  assign cpu_vector = vec_q;
  assign cpu_spurious = spur_q;
  assign vme_bus_req_n = ~req_q;
  assign vme_as_n = ~vas_q;
  assign vme_ds0_n = ~vds_q;
  assign vme_iack_n = ~viack_q;
  assign vme_ack_level = vlvl_q;
  assign expansion_strobe_n = ~xstb_q;
  assign expansion_reset_n = xrst_q;

endmodule // beh_top

// ==== include/beh_pkg.sv ====
package beh_pkg;

  // synchroniser bank layout, one bit per pin
  localparam int unsigned SYNC_W = 26;
  localparam int unsigned SY_DTACK = 0;
  localparam int unsigned SY_BERR = 1;
  localparam int unsigned SY_GRANT = 2;
  localparam int unsigned SY_EXP_ACK = 3;
  localparam int unsigned SY_ACFAIL = 4;
  localparam int unsigned SY_SYSFAIL = 5;
  localparam int unsigned SY_ABORT = 6;
  localparam int unsigned SY_XIRQ = 7;
  localparam int unsigned SY_VIRQ = 11;
  localparam int unsigned SY_DATA = 18;

  // register map
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] REG_CTRL_OFS = 12'h000;
  localparam logic [11:0] REG_STAT_OFS = 12'h004;
  localparam logic [11:0] REG_VTMO_OFS = 12'h008;
  localparam logic [11:0] REG_XTMO_OFS = 12'h00c;

  localparam int unsigned CTRL_PROTECT_MODE_BIT = 7;
  localparam int unsigned CTRL_WATCHDOG_ENABLE_BIT = 6;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam int unsigned STAT_ACFAIL_BIT = 0;
  localparam int unsigned STAT_SYSFAIL_BIT = 1;
  localparam int unsigned STAT_ABORT_BIT = 2;
  localparam int unsigned STAT_CAUSE_LSB = 4;
  localparam logic [15:0] VTMO_RST = 16'h0100;
  localparam logic [15:0] XTMO_RST = 16'h0040;
  localparam int unsigned PPROT_PRIV_BIT = 0;

  // level n autovector sits at base + 4*n (level 7 at 7C)
  localparam logic [7:0] AUTOVEC_BASE = 8'h60;

  typedef enum logic [2:0] {
    TGT_NONE, TGT_ROM, TGT_STATUS, TGT_CONTROL, TGT_TIMER, TGT_RAM, TGT_EXP, TGT_VME
  } beh_target_e;

  typedef enum logic [3:0] {
    CAUSE_NONE, CAUSE_ROM_WR, CAUSE_STAT_WR, CAUSE_CTRL_USER, CAUSE_TIMER_USER,
    CAUSE_RAM_WP, CAUSE_EXP_TMO, CAUSE_VME_TMO, CAUSE_VME_BERR, CAUSE_SPURIOUS
  } beh_cause_e;

  typedef enum logic [2:0] {
    ST_IDLE, ST_EXP, ST_VME_REQ, ST_VME_XFER, ST_ERR, ST_DONE
  } beh_state_e;

endpackage

// ==== include/beh_sync_if.sv ====
`timescale 1ns/1ps
interface beh_sync_if;
  logic [beh_pkg::SYNC_W-1:0] raw;
  logic [beh_pkg::SYNC_W-1:0] clean;
  modport bank(input raw, output clean);
  modport user(output raw, input clean);
endinterface // beh_sync_if

// ==== hdl/beh_sync_bank.sv ====
`timescale 1ns/1ps
module beh_sync_bank (
  input wire logic pclk,
  input wire logic presetn,
  beh_sync_if.bank sy
);
  import beh_pkg::*;

  // three stages; output moves only when stages two and three agree
  for (genvar i = 0; i < SYNC_W; i++) begin : g_bit
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic out_q;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        s1_q <= 1'b1;
        s2_q <= 1'b1;
        s3_q <= 1'b1;
        out_q <= 1'b1;
      end else begin
        s1_q <= sy.raw[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q) begin
          out_q <= s3_q;
        end
      end
    end
    assign sy.clean[i] = out_q;
  end
endmodule // beh_sync_bank

// ==== verif/beh_properties.sv ====
`timescale 1ns/1ps
module beh_properties
  import beh_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cpu_as_n,
  input wire logic cpu_write,
  input wire logic cpu_super,
  input wire logic cpu_iack,
  input wire logic [2:0] cpu_ack_level,
  input wire beh_pkg::beh_target_e cpu_target,
  input wire logic cpu_reset_instr,
  input wire logic processor_bus_error_n,
  input wire logic cpu_autovec_n,
  input wire logic [7:0] cpu_vector,
  input wire logic cpu_spurious,
  input wire logic vme_as_n,
  input wire logic vme_ds0_n,
  input wire logic vme_iack_n,
  input wire logic [2:0] vme_ack_level,
  input wire logic expansion_reset_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  property p_rom_wr;
    $fell(cpu_as_n) && cpu_write && cpu_target == TGT_ROM |=> !processor_bus_error_n;
  endproperty
  a_rom_wr: assert property (p_rom_wr) else $error("rom write not refused");
  property p_stat_wr;
    $fell(cpu_as_n) && cpu_write && cpu_target == TGT_STATUS |=> !processor_bus_error_n;
  endproperty
  a_stat_wr: assert property (p_stat_wr) else $error("status write not refused");
  property p_ctrl_wr;
    $fell(cpu_as_n) && cpu_write && cpu_target == TGT_CONTROL
      |=> processor_bus_error_n == $past(cpu_super);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write check wrong");
  property p_berr_hold;
    !processor_bus_error_n && !cpu_as_n |=> !processor_bus_error_n;
  endproperty
  a_berr_hold: assert property (p_berr_hold) else $error("bus error dropped early");
  property p_berr_rel;
    cpu_as_n && $past(cpu_as_n) |-> processor_bus_error_n;
  endproperty
  a_berr_rel: assert property (p_berr_rel) else $error("bus error outside cycle");
  // vector address follows the acknowledged level
  property p_autovec;
    !cpu_autovec_n |-> vme_iack_n && cpu_vector == AUTOVEC_BASE + {3'h0, cpu_ack_level, 2'h0};
  endproperty
  a_autovec: assert property (p_autovec) else $error("autovector wrong");
  property p_xrst;
    1'b1 |=> expansion_reset_n == !$past(cpu_reset_instr);
  endproperty
  a_xrst: assert property (p_xrst) else $error("expansion reset wrong");
  property p_spur;
    $fell(processor_bus_error_n) && cpu_iack |-> cpu_spurious;
  endproperty
  a_spur: assert property (p_spur) else $error("spurious flag missing");
  property p_ext_ack;
    !vme_iack_n |-> !vme_as_n && !vme_ds0_n && vme_ack_level == cpu_ack_level;
  endproperty
  a_ext_ack: assert property (p_ext_ack) else $error("external acknowledge wrong");
  c_auto: cover property ($fell(cpu_autovec_n));
  c_ext: cover property ($fell(vme_iack_n));
  c_spur: cover property ($fell(processor_bus_error_n) && cpu_iack);
endmodule // beh_properties

bind beh_top beh_properties beh_properties_inst (.pclk, .presetn, .cpu_as_n, .cpu_write,
  .cpu_super, .cpu_iack, .cpu_ack_level, .cpu_target, .cpu_reset_instr,
  .processor_bus_error_n, .cpu_autovec_n, .cpu_vector, .cpu_spurious, .vme_as_n,
  .vme_ds0_n, .vme_iack_n, .vme_ack_level, .expansion_reset_n);

// ==== verif/beh_far_model.sv ====
`timescale 1ns/1ps
module beh_far_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic vme_bus_req_n,
  input wire logic vme_as_n,
  input wire logic expansion_strobe_n,
  input wire logic [1:0] mode,
  input wire logic xsilent,
  input wire logic slow,
  input wire logic [7:0] vec,
  output logic vme_grant_n,
  output logic vme_dtack_n,
  output logic vme_berr_n,
  output logic [7:0] vme_data,
  output logic expansion_ack_n
);
  int vcnt;
  int xcnt;
  int dly;
  assign dly = slow ? 12 : 2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vme_grant_n <= 1'b1;
      vme_dtack_n <= 1'b1;
      vme_berr_n <= 1'b1;
      vme_data <= 8'h00;
      expansion_ack_n <= 1'b1;
      vcnt <= 0;
      xcnt <= 0;
    end else begin
      vme_grant_n <= vme_bus_req_n;
      vcnt <= vme_as_n ? 0 : vcnt + 1;
      xcnt <= expansion_strobe_n ? 0 : xcnt + 1;
      if (!vme_as_n && vcnt == dly && mode != 2'h2) begin
        vme_dtack_n <= mode[0];
        vme_berr_n <= !mode[0];
        vme_data <= vec;
      end else if (vme_as_n) begin
        // pulled-up lines rise, floating data keeps moving
        vme_dtack_n <= 1'b1;
        vme_berr_n <= 1'b1;
        vme_data <= ~vme_data;
      end
      if (!expansion_strobe_n && xcnt == dly && !xsilent) begin
        expansion_ack_n <= 1'b0;
      end else if (expansion_strobe_n) begin
        expansion_ack_n <= 1'b1;
      end
    end
  end
endmodule // beh_far_model

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import beh_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, seed = 32'h0000_001f;
  logic [2:0] pprot = 3'h1, cpu_ipl_n, vme_ack_level, cpu_ack_level = 3'h0;
  logic pready, pslverr, processor_bus_error_n, cpu_dtack_n, cpu_autovec_n, cpu_spurious;
  logic vme_bus_req_n, vme_as_n, vme_ds0_n, vme_iack_n, expansion_strobe_n, expansion_reset_n;
  logic vme_grant_n, vme_dtack_n, vme_berr_n, expansion_ack_n, err, b, a, d, s;
  logic [7:0] cpu_vector, vme_data, vec = 8'h00, v, ctl;
  logic cpu_as_n = 1, cpu_write = 0, cpu_super = 0, cpu_iack = 0, cpu_ram_wp = 0;
  logic cpu_reset_instr = 0, timer_irq = 0, serial_comm_adapter_irq = 0, xsilent = 0;
  logic acfail_n = 1, sysfail_n = 1, abort_n = 1, slow = 0;
  logic [7:1] vme_irq_n = 7'h7f;
  logic [4:1] expansion_irq_n = 4'hf;
  logic [1:0] mode = 2'h0;
  beh_target_e cpu_target = TGT_NONE, tt;
  logic [11:0] ofs [4] = '{REG_CTRL_OFS, REG_VTMO_OFS, REG_XTMO_OFS, 12'h010};
  logic [31:0] rv [4] = '{32'(CTRL_RST), 32'(VTMO_RST), 32'(XTMO_RST), 32'h0000_0000};
  int errors = 0, samples_checked = 0;
  always #2 pclk = ~pclk;
  beh_top beh_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pprot,
    .prdata, .pready, .pslverr, .cpu_as_n, .cpu_write, .cpu_super, .cpu_iack, .cpu_ack_level,
    .cpu_target, .cpu_ram_wp, .cpu_reset_instr, .timer_irq, .serial_comm_adapter_irq,
    .processor_bus_error_n, .cpu_ipl_n, .cpu_dtack_n, .cpu_autovec_n, .cpu_vector,
    .cpu_spurious, .vme_dtack_n, .vme_berr_n, .vme_grant_n, .vme_irq_n, .vme_data, .acfail_n,
    .sysfail_n, .abort_n, .vme_bus_req_n, .vme_as_n, .vme_ds0_n, .vme_iack_n, .vme_ack_level,
    .expansion_ack_n, .expansion_irq_n, .expansion_strobe_n, .expansion_reset_n);
  beh_far_model beh_far_model_inst (.pclk, .presetn, .vme_bus_req_n, .vme_as_n,
    .expansion_strobe_n, .mode, .xsilent, .slow, .vec, .vme_grant_n, .vme_dtack_n,
    .vme_berr_n, .vme_data, .expansion_ack_n);
  ////////////////////////////////////////////////////////////////////////////////
  task end_sim;
    if (errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic exp_berr(beh_target_e t, logic w, logic su, logic wp, logic [7:0] c);
    case (t)
      TGT_ROM, TGT_STATUS: return w;
      TGT_CONTROL: return w && !su;
      TGT_TIMER: return !su && c[CTRL_PROTECT_MODE_BIT] && c[CTRL_WATCHDOG_ENABLE_BIT];
      TGT_RAM: return w && !su && wp && c[CTRL_PROTECT_MODE_BIT];
      default: return 1'b0;
    endcase
  endfunction
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd, output logic [31:0] r,
           output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      errors++;
      end_sim();
    end
  endtask
  task cyc(input beh_target_e t, input logic w, input logic su, input logic ia,
           input logic [2:0] l, input int mx);
    int n;
    @(posedge pclk);
    cpu_as_n <= 1'b0;
    cpu_target <= t;
    cpu_write <= w;
    cpu_super <= su;
    cpu_iack <= ia;
    cpu_ack_level <= l;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (processor_bus_error_n === 1'b1 && cpu_autovec_n === 1'b1
               && cpu_dtack_n === 1'b1 && n < mx);
    if (n >= 100) begin
      errors++;
      end_sim();
    end
    b = processor_bus_error_n;
    a = cpu_autovec_n;
    d = cpu_dtack_n;
    v = cpu_vector;
    s = cpu_spurious;
    // hold the strobe a while so the error has to stand
    repeat (2) @(posedge pclk);
    cpu_as_n <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (90000) @(posedge pclk);
    errors++;
    end_sim();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ofs[i], 32'h0000_0000, rd, err);
      check(rd, rv[i]);
      check(err, i == 3);
    end
    apb(1'b1, REG_VTMO_OFS, 32'h0000_0028, rd, err);
    apb(1'b1, REG_XTMO_OFS, 32'h0000_0014, rd, err);
    apb(1'b1, REG_STAT_OFS, 32'h0000_00ff, rd, err);
    check(err, 1);
    pprot <= 3'h0;
    apb(1'b1, REG_CTRL_OFS, 32'h0000_00c0, rd, err);
    check(err, 1);
    pprot <= 3'h1;
    apb(1'b0, REG_CTRL_OFS, 32'h0000_0000, rd, err);
    check(rd, 0);
    for (int i = 0; i < 40; i++) begin
      // first five: each guarded target hit by a user write, guards on
      ctl = (i < 5) ? 8'hc0 : 8'(rnd()) & 8'hc0;
      apb(1'b1, REG_CTRL_OFS, {24'h00_0000, ctl}, rd, err);
      rd = rnd();
      if (i < 5) rd[10:0] = {3'(i + 1), 8'h03};
      tt = beh_target_e'(rd[10:8] % 3'h6);
      cpu_ram_wp <= rd[0];
      cyc(tt, rd[1], rd[2], 1'b0, 3'h0, 4);
      check(b, !exp_berr(tt, rd[1], rd[2], rd[0], ctl));
    end
    for (int i = 0; i < 5; i++) begin
      rd = rnd();
      slow <= rd[0];
      mode <= i[1:0];
      xsilent <= (i == 4);
      if (i < 3) cyc(TGT_VME, rd[1], 1'b1, 1'b0, 3'h0, 200);
      else cyc(TGT_EXP, rd[1], 1'b1, 1'b0, 3'h0, 200);
      check(b, i == 0 || i == 3);
      check(d, !(i == 0 || i == 3));
    end
    for (int l = 1; l < 8; l++) begin
      rd = rnd();
      // open-collector lines pulled low one at a time
      expansion_irq_n <= (l < 5) ? ~(4'h1 << (l - 1)) : 4'hf;
      serial_comm_adapter_irq <= (l == 5);
      timer_irq <= (l == 6);
      acfail_n <= !(l == 7 && rd[1:0] == 2'h0);
      sysfail_n <= !(l == 7 && rd[1:0] == 2'h1);
      abort_n <= !(l == 7 && rd[1:0] > 2'h1);
      vme_irq_n <= ~(7'h1 << (l - 1));
      repeat (8) @(posedge pclk);
      check(cpu_ipl_n, 3'(~l[2:0]));
      cyc(TGT_NONE, 1'b0, 1'b1, 1'b1, l[2:0], 20);
      check(a, 0);
      check(v, 8'(AUTOVEC_BASE + 4 * l));
      if (l == 7) begin
        apb(1'b0, REG_STAT_OFS, 32'h0000_0000, rd, err);
        check(rd[1:0], {!sysfail_n, !acfail_n});
      end
    end
    expansion_irq_n <= 4'hf;
    serial_comm_adapter_irq <= 1'b0;
    timer_irq <= 1'b0;
    acfail_n <= 1'b1;
    sysfail_n <= 1'b1;
    abort_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd = rnd();
      vec <= rd[7:0];
      slow <= rd[4];
      mode <= (i == 3) ? 2'h0 : i[1:0];
      vme_irq_n <= (i == 3) ? 7'h7f : ~(7'h1 << rd[9:8]);
      repeat (8) @(posedge pclk);
      cyc(TGT_NONE, 1'b0, 1'b1, 1'b1, {1'b0, rd[9:8]} + 3'h1, 200);
      check(d, i != 0);
      check(b, i == 0);
      check(s, i != 0);
      if (i == 0) check(v, rd[7:0]);
    end
    cpu_reset_instr <= 1'b1;
    repeat (3) @(posedge pclk);
    check(expansion_reset_n, 0);
    cpu_reset_instr <= 1'b0;
    repeat (3) @(posedge pclk);
    check(expansion_reset_n, 1);
    end_sim();
  end
endmodule // testbench
